// *** tb/scc_card_model.sv ***
// behavioural plug-in cards sitting in all five slots
`timescale 1ns/100ps
`default_nettype none
module scc_card_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // bus cycle and bench commands
  input  wire logic       addrStrobeN,
  input  wire logic       cfgWindow,
  input  wire logic       readCycle,
  input  wire logic [4:0] claim,
  input  wire logic [4:0] configured,
  // chain inputs from the motherboard, active low
  input  wire logic [4:0] configChainInN,
  // card lines, active low
  output logic      [4:0] cardSelectResponseN,
  output logic      [4:0] configChainOutN,
  // data buffer enable, wired over all cards, active high
  output logic            dataBufferOutputEnable
);
  logic [2:0] age;
  logic [4:0] answering;
  // config-window accesses reach only unconfigured cards whose chain input is asserted
  assign answering = cfgWindow ? (~configured & ~configChainInN) : claim;
  // writes open the buffers one clock into the cycle, reads only once the card has decoded
  assign dataBufferOutputEnable = !addrStrobeN && (answering != 5'h00) &&
                                  (readCycle ? (age >= 3'h3) : (age >= 3'h1));
  // cycles since strobe fell; cleared at the first edge after it rises
  always_ff @(posedge ref_clk) begin
    if (rst || addrStrobeN) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  // answer 24 ns in, released lines float to the pull-up level
  assign cardSelectResponseN = (age >= 3'h3) ? ~answering : 5'h1F;
  // chain out stays negated through reset until configured
  assign configChainOutN = rst ? 5'h1F : ~configured;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the slot collision and chain logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       addrStrobeN = 1'b1;
  logic       localBusAddress = 1'b0;
  logic [4:0] slotOccupied = 5'h1F;
  logic       coprocPresent = 1'b0;
  logic       coprocOutN = 1'b1;
  logic [4:0] claim = 5'h00;
  logic [4:0] configured = 5'h00;
  logic [4:0] selN;
  logic [4:0] chainOutN;
  logic [4:0] configChainInN;
  logic       busErrorOut;
  logic       busErrorOe;
  logic       cfgWindow = 1'b0;
  logic       readCycle = 1'b0;
  logic       dataBufEnable;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  scc_card_model cards (.ref_clk(ref_clk), .rst(rst), .addrStrobeN(addrStrobeN),
    .cfgWindow(cfgWindow), .readCycle(readCycle),
    .claim(claim), .configured(configured), .configChainInN(configChainInN),
    .cardSelectResponseN(selN), .configChainOutN(chainOutN),
    .dataBufferOutputEnable(dataBufEnable));
  scc_slot_control #(.NUM_SLOTS(5)) dut (.ref_clk(ref_clk), .rst(rst),
    .addrStrobeN(addrStrobeN), .localBusAddress(localBusAddress),
    .cardSelectResponseN(selN), .configChainOutN(chainOutN),
    .slotOccupied(slotOccupied), .coprocPresent(coprocPresent),
    .coprocConfigChainOutN(coprocOutN), .configChainInN(configChainInN),
    .busErrorLineOut(busErrorOut), .busErrorLineOe(busErrorOe));
  // free-running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang costs one mismatch; whole run needs about 220 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [4:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // set slots and coprocessor, then look at the chain two edges on
  task automatic chain_case(input logic [4:0] occ, cfg, input logic cp, cpN,
                            input logic [4:0] expIn);
    @(posedge ref_clk);
    slotOccupied <= occ;
    configured <= cfg;
    coprocPresent <= cp;
    coprocOutN <= cpN;
    repeat (2) @(posedge ref_clk);
    #1 chk("configChainInN", configChainInN, expIn);
  endtask
  // one access; settle window must stay quiet even when cards collide
  task automatic bus_cycle(input logic [4:0] who, input logic lb, expErr);
    logic rd;
    rd = ~readCycle;
    @(posedge ref_clk);
    claim <= who;
    localBusAddress <= lb;
    readCycle <= rd;
    addrStrobeN <= 1'b0;
    @(posedge ref_clk);
    #1 chk("dataBufferOutputEnable early", {4'h0, dataBufEnable}, {4'h0, (who != 5'h00) && !rd});
    repeat (3) @(posedge ref_clk);
    #1 chk("busErrorLineOe settle", {4'h0, busErrorOe}, 5'h00);
    chk("dataBufferOutputEnable", {4'h0, dataBufEnable}, {4'h0, who != 5'h00});
    repeat (8) @(posedge ref_clk);
    #1 chk("busErrorLineOe", {4'h0, busErrorOe}, {4'h0, expErr});
    chk("busErrorLineOut", {4'h0, busErrorOut}, 5'h00);
    @(posedge ref_clk);
    addrStrobeN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("busErrorLineOe end", {4'h0, busErrorOe}, 5'h00);
  endtask
  // strobe lifted during settle: colliding cards must not raise the line
  task automatic aborted_cycle(input logic [4:0] who);
    @(posedge ref_clk);
    claim <= who;
    localBusAddress <= 1'b0;
    addrStrobeN <= 1'b0;
    repeat (5) @(posedge ref_clk);
    addrStrobeN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("busErrorLineOe aborted", {4'h0, busErrorOe}, 5'h00);
  endtask
  // autoconfig access: only the first unconfigured card along the chain answers
  task automatic config_cycle(input logic [4:0] cfg, expSel);
    @(posedge ref_clk);
    configured <= cfg;
    cfgWindow <= 1'b1;
    localBusAddress <= 1'b0;
    repeat (2) @(posedge ref_clk);
    addrStrobeN <= 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 chk("cardSelectResponseN config", selN, expSel);
    chk("busErrorLineOe config", {4'h0, busErrorOe}, 5'h00);
    @(posedge ref_clk);
    addrStrobeN <= 1'b1;
    cfgWindow <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 chk("configChainInN reset", configChainInN, 5'h1F);
    @(posedge ref_clk);
    rst <= 1'b0;
    chain_case(5'h1F, 5'h00, 1'b0, 1'b1, 5'h1E);
    chain_case(5'h1F, 5'h01, 1'b0, 1'b1, 5'h1C);
    chain_case(5'h1F, 5'h07, 1'b0, 1'b1, 5'h10);
    chain_case(5'h1D, 5'h00, 1'b0, 1'b1, 5'h1E);
    chain_case(5'h1D, 5'h01, 1'b0, 1'b1, 5'h18);
    chain_case(5'h0A, 5'h00, 1'b0, 1'b1, 5'h1C);
    chain_case(5'h1F, 5'h00, 1'b1, 1'b1, 5'h1F);
    chain_case(5'h1F, 5'h01, 1'b1, 1'b0, 5'h1C);
    chain_case(5'h1F, 5'h0F, 1'b1, 1'b0, 5'h00);
    config_cycle(5'h01, 5'h1D);
    config_cycle(5'h00, 5'h1E);
    aborted_cycle(5'h03);
    bus_cycle(5'h00, 1'b0, 1'b0);
    bus_cycle(5'h01, 1'b0, 1'b0);
    bus_cycle(5'h03, 1'b0, 1'b1);
    bus_cycle(5'h0C, 1'b0, 1'b1);
    bus_cycle(5'h18, 1'b0, 1'b1);
    bus_cycle(5'h1F, 1'b0, 1'b1);
    bus_cycle(5'h10, 1'b1, 1'b1);
    bus_cycle(5'h00, 1'b1, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// *** verilog/scc_chain_link.sv ***
// one stage of the configuration chain
`timescale 1ns/100ps
`default_nettype none
module scc_chain_link (
  // chain from the slot before
  input  wire logic prevAsserted,
  // this slot
  input  wire logic slotOccupied,
  input  wire logic configChainOutN,
  // towards the next slot
  output logic      passAsserted
);
  // an empty slot is transparent, a filled one forwards its card's output
  assign passAsserted = slotOccupied ? ~configChainOutN : prevAsserted;  // [R9] [R10]
endmodule
`default_nettype wire

// *** verilog/scc_pkg.sv ***
// constants shared by the slot collision and configuration chain logic
// Summary of operation
// (R1) Every expansion slot has its own card-select response input and all of them feed the collision detector.
// (R2) A card that decodes its address asserts its card-select response within 35 ns of the access.
// (R3) A card releases its card-select response within 50 ns after the bus cycle ends.
// (R4) Two or more responses for one address, or any response to a local-bus address, raise the bus error line.
// (R5) Each slot's chain input follows from the chain outputs of all earlier slots, in order slot 1 to slot 5; the code follows only the nearest filled one.
// (R6) A present coprocessor slot sits at chain priority 0 and its chain output feeds slot 1 directly.
// (R7) An unconfigured card answers the 64K window at E80000 only while its chain input is asserted.
// (R8) A card holds its chain output negated from power-up or reset until it is configured.
// (R9) A card asserts its chain output once configured or shut up, and the next slot's chain input then asserts.
// (R10) An empty slot passes the previous slot's chain state straight on to the next slot.
// (R11) A card drives the data buffer output enable with different timing for reads and writes.
// (R12) Responses are sampled only while the address strobe is asserted, and the collision clears when the cycle ends.
`default_nettype none
package scc_pkg;
  localparam int SCC_NUM_SLOTS        = 5;
  localparam int SCC_CLK_PERIOD_NS    = 8;
  // card-side response timing, turned into whole clock cycles
  localparam int SCC_SELECT_ASSERT_NS  = 35;
  localparam int SCC_SELECT_ASSERT_CYC = (SCC_SELECT_ASSERT_NS + SCC_CLK_PERIOD_NS - 1) / SCC_CLK_PERIOD_NS;
  localparam int SCC_SELECT_RELEASE_NS = 50;
  localparam int SCC_SELECT_RELEASE_CYC = SCC_SELECT_RELEASE_NS / SCC_CLK_PERIOD_NS;
  // wait covers both a late assert and a stale release from the last cycle
  localparam int SCC_SETTLE_CYC = (SCC_SELECT_ASSERT_CYC > SCC_SELECT_RELEASE_CYC) ?
                                  SCC_SELECT_ASSERT_CYC : SCC_SELECT_RELEASE_CYC;
  localparam int SCC_COUNT_W    = 4;
  localparam logic [SCC_COUNT_W-1:0] SCC_SETTLE_LAST = SCC_COUNT_W'(SCC_SETTLE_CYC - 1);
  // reset values
  localparam logic SCC_RST_CHAIN_IN_N = 1'b1;
  localparam logic SCC_RST_BUS_ERROR_OE = 1'b0;
  localparam logic SCC_BUS_ERROR_LEVEL  = 1'b0;
  typedef enum logic [1:0] {CYC_IDLE, CYC_SETTLE, CYC_SAMPLE, CYC_FAULT} scc_cycle_type;
endpackage
`default_nettype wire

// *** verilog/scc_slot_control.sv ***
// motherboard slot collision detector and configuration chain
`timescale 1ns/100ps
`default_nettype none
module scc_slot_control
  import scc_pkg::*;
#(
  parameter int NUM_SLOTS = SCC_NUM_SLOTS
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // processor bus cycle
  input  wire logic                 addrStrobeN,
  input  wire logic                 localBusAddress,
  // per-slot card lines, active low, and slot-occupied flags, active high
  input  wire logic [NUM_SLOTS-1:0] cardSelectResponseN,
  input  wire logic [NUM_SLOTS-1:0] configChainOutN,
  input  wire logic [NUM_SLOTS-1:0] slotOccupied,
  // coprocessor slot
  input  wire logic                 coprocPresent,
  input  wire logic                 coprocConfigChainOutN,
  // chain inputs towards the slots, active low
  output logic      [NUM_SLOTS-1:0] configChainInN,
  // open-drain bus error line
  output logic                      busErrorLineOut,
  output logic                      busErrorLineOe
);

  // refuse sizes the chain and counters are not built for
  if (NUM_SLOTS < 2 || NUM_SLOTS > 15) begin : gSizeCheck
    $error("NUM_SLOTS must lie between 2 and 15");
  end

  logic [NUM_SLOTS:0]     chainAsserted;
  logic [NUM_SLOTS-1:0]   next_configChainInN;
  scc_cycle_type          cycState;
  scc_cycle_type          next_cycState;
  logic [SCC_COUNT_W-1:0] settleCount;
  logic [SCC_COUNT_W-1:0] next_settleCount;
  logic                   next_busErrorLineOe;
  logic [SCC_COUNT_W-1:0] respCount;
  logic                   collide;

  // head of chain: coprocessor when fitted, otherwise slot 1 is always enabled
  assign chainAsserted[0] = coprocPresent ? ~coprocConfigChainOutN : 1'b1;  // [R6]

  // one link per slot, each input built from the previous link's output
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : gChain
    scc_chain_link uLink (
      .prevAsserted    (chainAsserted[i]),
      .slotOccupied    (slotOccupied[i]),
      .configChainOutN (configChainOutN[i]),
      .passAsserted    (chainAsserted[i+1])
    );
  end

  // chain inputs, active low on the slot pins
  always_comb begin
    next_configChainInN = ~chainAsserted[NUM_SLOTS-1:0];  // [R5]
  end

  // chain inputs are registered so every pin comes from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      configChainInN <= {NUM_SLOTS{SCC_RST_CHAIN_IN_N}};
    end else begin
      configChainInN <= next_configChainInN;
    end
  end

  // count responding slots; every slot line has its own input
  always_comb begin
    respCount = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      // zero-extend the single active bit before adding; a sized cast would invert the extension bits too
      respCount = respCount + {{(SCC_COUNT_W-1){1'b0}}, ~cardSelectResponseN[i]};  // [R1]
    end
    collide = (respCount > SCC_COUNT_W'(1)) || ((respCount != '0) && localBusAddress);  // [R4]
  end

  // cycle tracker: wait for responses to settle, sample, hold a fault until strobe ends
  always_comb begin
    next_cycState    = cycState;
    next_settleCount = settleCount;
    case (cycState)
      CYC_IDLE: begin
        next_settleCount = '0;
        if (!addrStrobeN) begin
          next_cycState = CYC_SETTLE;  // [R12]
        end
      end
      CYC_SETTLE: begin
        if (addrStrobeN) begin
          next_cycState = CYC_IDLE;
        end else if (settleCount == SCC_SETTLE_LAST) begin
          next_cycState = CYC_SAMPLE;  // [R2] [R3]
        end else begin
          next_settleCount = settleCount + SCC_COUNT_W'(1);
        end
      end
      CYC_SAMPLE: begin
        if (addrStrobeN) begin
          next_cycState = CYC_IDLE;  // [R12]
        end else if (collide) begin
          next_cycState = CYC_FAULT;  // [R4]
        end
      end
      CYC_FAULT: begin
        if (addrStrobeN) begin
          next_cycState = CYC_IDLE;  // [R12]
        end
      end
      default: begin
        next_cycState = CYC_IDLE;
      end
    endcase
    next_busErrorLineOe = (next_cycState == CYC_FAULT);  // [R4]
  end

  // cycle tracker registers; the line only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cycState        <= CYC_IDLE;
      settleCount     <= '0;
      busErrorLineOe  <= SCC_RST_BUS_ERROR_OE;
      busErrorLineOut <= SCC_BUS_ERROR_LEVEL;
    end else begin
      cycState        <= next_cycState;
      settleCount     <= next_settleCount;
      busErrorLineOe  <= next_busErrorLineOe;
      busErrorLineOut <= SCC_BUS_ERROR_LEVEL;
    end
  end

  // checks
  default clocking cbMain @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_COLLIDE_RAISES_BUS_ERROR_LINE: assert property (  // [R4]
    (cycState == CYC_SAMPLE && !addrStrobeN && collide) |=> busErrorLineOe)
    else $error("collision did not raise bus error");

  AST_SINGLE_NO_BUS_ERROR_LINE: assert property (  // [R1]
    (cycState == CYC_SAMPLE && !addrStrobeN && respCount == SCC_COUNT_W'(1) && !localBusAddress)
      |=> !busErrorLineOe)
    else $error("single local-free responder raised bus error");

  AST_NO_EARLY_SAMPLE: assert property (  // [R12]
    $rose(busErrorLineOe) |-> !$past(addrStrobeN, 1) && !$past(addrStrobeN, 8))
    else $error("bus error raised before responses settled");

  AST_CLEAR_AT_END: assert property (  // [R12]
    addrStrobeN |=> !busErrorLineOe)
    else $error("bus error held after strobe negated");

  AST_COPROC_HEAD: assert property (  // [R6]
    !$past(rst) && $past(coprocPresent) |-> configChainInN[0] == $past(coprocConfigChainOutN))
    else $error("slot 1 chain input does not follow coprocessor");

  AST_EMPTY_PASSES: assert property (  // [R10]
    !$past(rst) && $past(!slotOccupied[0]) |-> configChainInN[1] == configChainInN[0])
    else $error("empty slot did not pass chain state");

  AST_DONE_ENABLES_NEXT: assert property (  // [R9]
    !$past(rst) && $past(slotOccupied[0] && !configChainOutN[0]) |-> !configChainInN[1])
    else $error("configured card did not enable next slot");

  AST_PENDING_BLOCKS: assert property (  // [R5]
    !$past(rst) && $past(slotOccupied[0] && configChainOutN[0]) |-> configChainInN[1])
    else $error("unconfigured card let chain pass");

  COV_FAULT: cover property (cycState == CYC_SAMPLE ##1 busErrorLineOe ##[1:20] !busErrorLineOe);
  COV_LOCAL_CLAIM: cover property (cycState == CYC_SAMPLE && localBusAddress && respCount != '0);
  COV_CHAIN_LAST: cover property (!configChainInN[NUM_SLOTS-1] && coprocPresent);

endmodule
`default_nettype wire
